// File: core/boot_arbiter.sv
// Notes on behaviour
// - one to fifteen units share the bus
// - arbitrate after hard reset, set winner flag
// - soft init never re-arbitrates; flag decides
// - own id in low vector nibble
// - claim vector upper nibble is four
// - winner sends final message, then fetches
// - startup message: mode 110, edge, assert
// - bus error during arbitration means shutdown
// - failed self test still arbitrates
// - claim to all including self after test
// - hold claim until all tests done
// - first claim raises core interrupt
// - first claim id match picks the winner
// - one atomic message on the bus
// - round-robin priority for bus access
// - winner priority drops to zero
// - application units halt until startup message
`timescale 1ns/1ps
module boot_arbiter
    import boot_arb_pkg::*;
#(
    parameter logic [3:0] UNIT_ID = 4'h0
) (
    // core clock and reset
    input wire logic clock,
    input wire logic rst,
    // interrupt bus
    input wire logic interruptBusClock,
    input wire logic busIn,
    output logic busOut_r,
    output logic busOe_r,
    // board pins, active low
    input wire logic blockNextRequestPin_n,
    input wire logic priorityAgentRequestPin_n,
    input wire logic softInitPin_n,
    // core side
    input wire logic selfTestDone,
    input wire logic unitEnabled,
    input wire logic [3:0] logicalId,
    // results to the core
    output logic bootstrapFlag_r,
    output logic coreIrq_r,
    output logic fetchResetVector_r,
    output logic startupWake_r,
    output logic [7:0] startupVector_r,
    output logic halted_r,
    output logic shutdown_r,
    output logic arbDone_r
);
    // id F is reserved, so at most fifteen units exist
    if (UNIT_ID == BAD_ID) begin : g_bad_id
        $error("unit id must not be the reserved value");
    end

    boot_state_t state_r, state_nxt;    // boot flow
    logic [1:0] bnrSync_r;              // pin synchronisers
    logic [1:0] bpriSync_r;
    logic [1:0] softSync_r;
    logic softPrev_r;                   // for edge detect
    logic busFree;                      // no unit still in test
    logic softInitEdge;
    logic txToggle_r;                   // send request
    logic [WORD_W-1:0] txWord_r;        // held until sent
    logic linkToggle;                   // report toggle from link
    logic [REP_W-1:0] linkWord;         // stable between toggles
    logic [1:0] repSync_r;
    logic repSeen_r;
    logic rxValid_r;                    // one cycle per frame
    logic [REP_W-1:0] rep_r;            // captured report
    logic [7:0] rVec;
    logic [2:0] rMode;
    logic rClean;                       // checksum and acceptance ok
    logic claimSeen, rxErr, finalMine, startHit, initMsg, initEvent;
    logic inArb;

    // destination check for physical or logical mode
    function automatic logic destHit(input logic dMode, input logic [3:0] dest, input logic [3:0] lid);
        if (dMode == DEST_PHYS) begin
            return dest == UNIT_ID || dest == ALL_DEST;
        end
        return (dest & lid) != 4'h0;
    endfunction

    // message word for a boot-phase send to all including self
    function automatic logic [WORD_W-1:0] bootWord(input logic [3:0] gen);
        return {makeVector(gen, UNIT_ID), MODE_FIXED, TRIG_EDGE, LEVEL_DEASSERT, DEST_PHYS, ALL_DEST};
    endfunction

    // serial engine on the interrupt bus clock
    bus_link_engine #(
        .START_PRIO(UNIT_ID)
    ) u_link (
        .busClock(interruptBusClock),
        .rst(rst),
        .txToggle(txToggle_r),
        .txWord(txWord_r),
        .busIn(busIn),
        .busOut_r(busOut_r),
        .busOe_r(busOe_r),
        .repToggle_r(linkToggle),
        .repWord_r(linkWord)
    );

    // pin synchronisers, second stage only is read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bnrSync_r <= 2'b11;
            bpriSync_r <= 2'b11;
            softSync_r <= 2'b11;
            softPrev_r <= 1'b1;
        end else begin
            bnrSync_r <= {bnrSync_r[0], blockNextRequestPin_n};
            bpriSync_r <= {bpriSync_r[0], priorityAgentRequestPin_n};
            softSync_r <= {softSync_r[0], softInitPin_n};
            softPrev_r <= softSync_r[1];
        end
    end

    // both pins released: every unit finished self
    assign busFree = bnrSync_r[1] && bpriSync_r[1];
    assign softInitEdge = softPrev_r && !softSync_r[1];

    // report crossing: toggle synchronised, word then stable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            repSync_r <= 2'b00;
            repSeen_r <= 1'b0;
            rxValid_r <= 1'b0;
            rep_r <= '0;
        end else begin
            repSync_r <= {repSync_r[0], linkToggle};
            rxValid_r <= repSync_r[1] ^ repSeen_r;
            if (repSync_r[1] ^ repSeen_r) begin
                repSeen_r <= repSync_r[1];
                rep_r <= linkWord;
            end
        end
    end

    // report decode
    assign rVec = rep_r[VEC_LSB +: VEC_W];
    assign rMode = rep_r[MODE_LSB +: 3];
    assign rClean = rep_r[REP_CS] && rep_r[REP_ACC];
    assign claimSeen = rxValid_r && rClean && rVec[7:4] == CLAIM_GEN && rMode == MODE_FIXED;
    assign rxErr = rxValid_r && !rClean;
    assign finalMine = rxValid_r && rClean && rep_r[REP_MINE] && rVec == makeVector(FINAL_GEN, UNIT_ID);
    // startup: mode 110, edge, assert, addressed here
    assign startHit = rxValid_r && rClean && rMode == MODE_STARTUP && rep_r[TRIG_POS] == TRIG_EDGE
        && rep_r[LEVEL_POS] == LEVEL_ASSERT && destHit(rep_r[DMODE_POS], rep_r[3:0], logicalId);
    // an init message reaches a unit only if enabled or the winner
    assign initMsg = rxValid_r && rClean && rMode == MODE_INIT
        && destHit(rep_r[DMODE_POS], rep_r[3:0], logicalId) && (unitEnabled || bootstrapFlag_r);
    assign initEvent = softInitEdge || initMsg;
    assign inArb = state_r == ST_BUSWAIT || state_r == ST_CLAIM || state_r == ST_FINAL;

    // next state of the boot flow
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_TEST: begin
                // self test result is not consulted
                if (selfTestDone) begin
                    state_nxt = ST_BUSWAIT;
                end
            end
            ST_BUSWAIT: begin
                if (rxErr) begin
                    state_nxt = ST_SHUT;
                end else if (busFree) begin
                    state_nxt = ST_CLAIM;
                end
            end
            ST_CLAIM: begin
                if (rxErr) begin
                    state_nxt = ST_SHUT;
                end else if (claimSeen && rVec[3:0] == UNIT_ID) begin
                    state_nxt = ST_FINAL;
                end else if (claimSeen) begin
                    state_nxt = ST_APWAIT;
                end
            end
            ST_FINAL: begin
                if (rxErr) begin
                    state_nxt = ST_SHUT;
                end else if (finalMine) begin
                    state_nxt = ST_BOOT;
                end
            end
            ST_BOOT, ST_APWAIT: begin
                // soft init picks a path from the flag only
                if (initEvent) begin
                    state_nxt = bootstrapFlag_r ? ST_BOOT : ST_APWAIT;
                end
            end
            ST_SHUT: begin
                state_nxt = ST_SHUT;
            end
            default: begin
                state_nxt = ST_SHUT;
            end
        endcase
    end

    // state register: only hard reset starts arbitration
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= ST_TEST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // boot-phase sends: claim then, for the winner, final
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txToggle_r <= 1'b0;
            txWord_r <= '0;
        end else if (state_r == ST_BUSWAIT && state_nxt == ST_CLAIM) begin
            txWord_r <= bootWord(CLAIM_GEN);
            txToggle_r <= ~txToggle_r;
        end else if (state_r == ST_CLAIM && state_nxt == ST_FINAL) begin
            txWord_r <= bootWord(FINAL_GEN);
            txToggle_r <= ~txToggle_r;
        end
    end

    // bootstrap flag: cleared by reset, set only by the first claim
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bootstrapFlag_r <= 1'b0;
        end else if (state_r == ST_CLAIM && claimSeen && !rxErr) begin
            bootstrapFlag_r <= rVec[3:0] == UNIT_ID;
        end
    end

    // core-facing events and levels
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            coreIrq_r <= 1'b0;
            fetchResetVector_r <= 1'b0;
            startupWake_r <= 1'b0;
            startupVector_r <= 8'h00;
            halted_r <= 1'b1;
            shutdown_r <= 1'b0;
            arbDone_r <= 1'b0;
        end else begin
            // first completed claim interrupts the core
            coreIrq_r <= state_r == ST_CLAIM && claimSeen;
            fetchResetVector_r <= state_nxt == ST_BOOT && (state_r == ST_FINAL || initEvent);
            startupWake_r <= 1'b0;
            shutdown_r <= shutdown_r || state_nxt == ST_SHUT;
            // devices may raise requests once this is high
            arbDone_r <= state_nxt == ST_BOOT || state_nxt == ST_APWAIT;
            if (state_nxt == ST_BOOT) begin
                halted_r <= 1'b0;
            end else if (state_r == ST_CLAIM && state_nxt == ST_APWAIT) begin
                halted_r <= 1'b1;
            end else if (state_r == ST_APWAIT && initEvent) begin
                halted_r <= 1'b1;
            end else if (state_r == ST_APWAIT && startHit) begin
                // startup message wakes a halted unit
                halted_r <= 1'b0;
                startupWake_r <= 1'b1;
                startupVector_r <= rVec;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // steps of arbitration
    sequence claimWon;
        state_r == ST_CLAIM && claimSeen && !rxErr && rVec[3:0] == UNIT_ID;
    endsequence
    sequence claimLost;
        state_r == ST_CLAIM && claimSeen && !rxErr && rVec[3:0] != UNIT_ID;
    endsequence

    a_claim_vector: assert property (state_r == ST_CLAIM && $changed(txToggle_r)
        |-> txWord_r[VEC_LSB +: VEC_W] == {4'h4, UNIT_ID})
        else $error("claim vector wrong");
    a_own_nibble: assert property ($changed(txToggle_r)
        |-> txWord_r[VEC_LSB +: 4] == UNIT_ID && txWord_r[VEC_LSB +: VEC_W] != 8'h4F)
        else $error("vector does not carry own id");
    a_claim_waits_pins: assert property (state_r == ST_CLAIM && $changed(txToggle_r)
        |-> $past(bnrSync_r[1] && bpriSync_r[1]))
        else $error("claim sent while a unit is in test");
    a_irq_on_claim: assert property (claimWon or claimLost |=> coreIrq_r ##1 !coreIrq_r)
        else $error("no single interrupt on first claim");
    a_winner_flag: assert property (claimWon |=> bootstrapFlag_r && state_r == ST_FINAL
        && txWord_r[VEC_LSB +: VEC_W] == {4'h1, UNIT_ID})
        else $error("winner did not take flag and send final");
    a_loser_halts: assert property (claimLost |=> !bootstrapFlag_r && halted_r && state_r == ST_APWAIT)
        else $error("loser not halted");
    a_final_fetch: assert property (state_r == ST_FINAL && finalMine && !rxErr
        |=> fetchResetVector_r && !halted_r && state_r == ST_BOOT)
        else $error("no fetch after own final");
    a_error_shutdown: assert property (inArb && rxErr |=> shutdown_r [*3])
        else $error("bus error did not shut down");
    a_no_rearbitrate: assert property (arbDone_r && initEvent |=> arbDone_r && $stable(txToggle_r)
        && state_r == ($past(bootstrapFlag_r) ? ST_BOOT : ST_APWAIT))
        else $error("arbitration restarted after soft init");
    a_startup_wake: assert property (state_r == ST_APWAIT && startHit && !initEvent
        |=> startupWake_r && startupVector_r == $past(rVec) && !halted_r)
        else $error("startup message did not wake unit");
    a_reset_flag: assert property (state_r == ST_TEST |-> !bootstrapFlag_r && !arbDone_r)
        else $error("flag set before arbitration");
endmodule

// File: common/boot_arb_pkg.sv
package boot_arb_pkg;
    // field and frame widths
    localparam int ID_W = 4;
    localparam int VEC_W = 8;
    localparam int ARB_W = 4;
    localparam int WORD_W = 18;
    localparam int SUM_W = 2;
    localparam int FRAME_W = ARB_W + WORD_W + SUM_W;
    localparam int REP_W = WORD_W + 3;
    // message word layout: vector, mode, trigger, level, dest mode, dest
    localparam int VEC_LSB = 10;
    localparam int MODE_LSB = 7;
    localparam int TRIG_POS = 6;
    localparam int LEVEL_POS = 5;
    localparam int DMODE_POS = 4;
    // report word flags above the message word
    localparam int REP_CS = 18;
    localparam int REP_ACC = 19;
    localparam int REP_MINE = 20;
    // bit indices inside a frame (bit 0 is the start bit)
    localparam logic [4:0] BIT_FIRST = 5'h01;
    localparam logic [4:0] BIT_ARB_LAST = 5'h04;
    localparam logic [4:0] BIT_TX_LAST = 5'h17;
    localparam logic [4:0] BIT_SUM_LAST = 5'h18;
    localparam logic [4:0] BIT_STATUS = 5'h19;
    // vector generation codes and ids
    localparam logic [3:0] CLAIM_GEN = 4'h4;
    localparam logic [3:0] FINAL_GEN = 4'h1;
    localparam logic [3:0] BAD_ID = 4'hF;
    localparam logic [3:0] ALL_DEST = 4'hF;
    // delivery modes and flag values
    localparam logic [2:0] MODE_FIXED = 3'h0;
    localparam logic [2:0] MODE_INIT = 3'h5;
    localparam logic [2:0] MODE_STARTUP = 3'h6;
    localparam logic TRIG_EDGE = 1'b0;
    localparam logic LEVEL_ASSERT = 1'b1;
    localparam logic LEVEL_DEASSERT = 1'b0;
    localparam logic DEST_PHYS = 1'b0;

    // boot flow states, gray along the winning path
    typedef enum logic [2:0] {
        ST_TEST = 3'b000,
        ST_BUSWAIT = 3'b001,
        ST_CLAIM = 3'b011,
        ST_FINAL = 3'b010,
        ST_BOOT = 3'b110,
        ST_APWAIT = 3'b100,
        ST_SHUT = 3'b101
    } boot_state_t;

    // vector from generation code and unit id
    function automatic logic [7:0] makeVector(input logic [3:0] gen, input logic [3:0] id);
        return {gen, id};
    endfunction

    // two-bit running sum of the ones in a message word
    function automatic logic [1:0] sumOf(input logic [17:0] d);
        logic [1:0] s;
        s = 2'h0;
        for (int i = 0; i < WORD_W; i++) begin
            s = s + {1'b0, d[i]};
        end
        return s;
    endfunction
endpackage

// File: core/bus_link_engine.sv
`timescale 1ns/1ps
module bus_link_engine
    import boot_arb_pkg::*;
#(
    parameter logic [3:0] START_PRIO = 4'h0
) (
    // link clock and system reset
    input wire logic busClock,
    input wire logic rst,
    // send request from the core domain
    input wire logic txToggle,
    input wire logic [WORD_W-1:0] txWord,
    // open-drain serial bus line
    input wire logic busIn,
    output logic busOut_r,
    output logic busOe_r,
    // one report per completed frame
    output logic repToggle_r,
    output logic [REP_W-1:0] repWord_r
);
    logic [1:0] rstPipe_r;            // reset release synchroniser
    logic linkRst;
    logic txSync1_r, txSync2_r;       // send toggle synchroniser
    logic txSeen_r;                   // last toggle served
    logic pending;
    logic busLow;                     // dominant level on the line
    logic inFrame_r;
    logic [4:0] bitCnt_r;             // index of next sampled bit
    logic sending_r;
    logic stillSending;
    logic [FRAME_W-1:0] txFrame_r;    // bits still to drive
    logic [FRAME_W-1:0] txLoad;
    logic [FRAME_W-2:0] rxShift_r;
    logic [FRAME_W-1:0] rxFull;
    logic [ARB_W-1:0] prio_r, winPrio_r;
    logic csOk_r;
    logic [WORD_W-1:0] rxData_r;

    assign linkRst = rstPipe_r[1];
    assign pending = txSync2_r ^ txSeen_r;
    assign busLow = ~busIn;
    assign txLoad = {prio_r, txWord, sumOf(txWord)};
    assign rxFull = {rxShift_r, busLow};
    // a contender that drove recessive but sees dominant in a priority bit has lost
    assign stillSending = sending_r && !(bitCnt_r <= BIT_ARB_LAST && !busOe_r && busLow);

    // reset: asserted at once, released on the link clock
    always_ff @(posedge busClock or posedge rst) begin
        if (rst) begin
            rstPipe_r <= 2'b11;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b0};
        end
    end

    // send toggle crossing; word is held stable while pending
    always_ff @(posedge busClock or posedge linkRst) begin
        if (linkRst) begin
            txSync1_r <= 1'b0;
            txSync2_r <= 1'b0;
        end else begin
            txSync1_r <= txToggle;
            txSync2_r <= txSync1_r;
        end
    end

    // frame engine: join, arbitrate, shift, check, accept
    always_ff @(posedge busClock or posedge linkRst) begin
        if (linkRst) begin
            busOut_r <= 1'b0;
            busOe_r <= 1'b0;
            inFrame_r <= 1'b0;
            bitCnt_r <= 5'h00;
            sending_r <= 1'b0;
            txFrame_r <= '0;
            rxShift_r <= '0;
            prio_r <= START_PRIO;
            winPrio_r <= 4'h0;
            csOk_r <= 1'b0;
            rxData_r <= '0;
            txSeen_r <= 1'b0;
            repToggle_r <= 1'b0;
            repWord_r <= '0;
        end else if (!inFrame_r) begin
            busOut_r <= 1'b0;
            if (busLow) begin
                // start bit seen: every pending agent contends
                inFrame_r <= 1'b1;
                bitCnt_r <= BIT_FIRST;
                sending_r <= pending || sending_r;
                busOe_r <= (pending || sending_r) && txLoad[FRAME_W-1];
                txFrame_r <= {txLoad[FRAME_W-2:0], 1'b0};
            end else begin
                // a new frame starts only on an idle line
                sending_r <= pending;
                busOe_r <= pending;
            end
        end else begin
            // a started frame always runs to its status bit
            bitCnt_r <= bitCnt_r + 5'h01;
            sending_r <= stillSending;
            if (bitCnt_r <= BIT_SUM_LAST) begin
                rxShift_r <= rxFull[FRAME_W-2:0];
            end
            if (bitCnt_r == BIT_ARB_LAST) begin
                winPrio_r <= rxFull[ARB_W-1:0];
            end
            if (bitCnt_r <= BIT_TX_LAST) begin
                // losers fall silent for the rest of the frame up to its status bit
                busOe_r <= stillSending && txFrame_r[FRAME_W-1];
                txFrame_r <= {txFrame_r[FRAME_W-2:0], 1'b0};
            end else if (bitCnt_r == BIT_SUM_LAST) begin
                // every agent, sender included, accepts a clean frame
                csOk_r <= sumOf(rxFull[WORD_W+SUM_W-1:SUM_W]) == rxFull[SUM_W-1:0];
                rxData_r <= rxFull[WORD_W+SUM_W-1:SUM_W];
                busOe_r <= sumOf(rxFull[WORD_W+SUM_W-1:SUM_W]) == rxFull[SUM_W-1:0];
            end else begin
                // status bit: report the frame and rotate priorities
                busOe_r <= 1'b0;
                inFrame_r <= 1'b0;
                repWord_r <= {sending_r, busLow, csOk_r, rxData_r};
                repToggle_r <= ~repToggle_r;
                if (sending_r) begin
                    txSeen_r <= txSync2_r;
                    prio_r <= 4'h0;
                end else if (prio_r < winPrio_r) begin
                    prio_r <= prio_r + 4'h1;
                end
            end
        end
    end
endmodule

// File: tb/bus_agent_model.sv
`timescale 1ns/1ps
module bus_agent_model
    import boot_arb_pkg::*;
(
    // link clock and wired line level
    input wire logic busClock,
    input wire logic busIn,
    // high pulls the line low
    output logic busOe
);
    logic sendOe = 1'b0; // own frame bits
    logic ackOe = 1'b0; // status bit accept
    logic [3:0] prio = 4'h5; // round-robin priority
    int cnt = 0; // bit position, 0 when idle
    int frames = 0; // completed frames seen
    logic [19:0] shreg = '0; // word and sum bits
    logic [WORD_W-1:0] words [8]; // log of frame words
    assign busOe = sendOe | ackOe;
    // track every frame, log its word, accept a good sum
    always @(posedge busClock) begin
        if (cnt == 0) begin
            // an unknown line before reset settles is not a start bit
            cnt <= (busIn === 1'b0) ? 1 : 0;
        end else begin
            cnt <= (cnt == 25) ? 0 : cnt + 1;
        end
        if (cnt >= 5 && cnt <= 24) begin
            shreg <= {shreg[18:0], ~busIn};
        end
        ackOe <= (cnt == 24) && ({shreg[0], ~busIn} == 2'($countones(shreg[18:1])));
        if (cnt == 25) begin
            words[frames[2:0]] <= shreg[19:2];
            frames <= frames + 1;
        end
    end
    // send one frame; a lost arbitration releases and retries
    task automatic sendFrame(input logic [WORD_W-1:0] w, input logic badSum);
        logic [26:0] f;
        logic lost;
        logic [3:0] wp;
        lost = 1'b1;
        while (lost) begin
            f = {1'b1, prio, w, 2'($countones(w)) ^ {2{badSum}}, 2'b10};
            lost = 1'b0;
            wp = 4'h0;
            @(posedge busClock);
            while (cnt != 0 || busIn !== 1'b1) @(posedge busClock);
            sendOe <= 1'b1;
            for (int b = 1; b <= 26; b++) begin
                @(posedge busClock);
                if (b >= 2 && b <= 5) begin
                    wp = {wp[2:0], ~busIn};
                    lost = lost | (!sendOe && !busIn);
                end
                sendOe <= !lost && f[26-b];
            end
            prio = !lost ? 4'h0 : (prio < wp ? prio + 4'h1 : prio);
        end
    endtask
endmodule

// File: tb/test_boot_arbiter.sv
`timescale 1ns/1ps
module test_boot_arbiter
    import boot_arb_pkg::*;
;
    logic clock = 1'b0;
    logic busClock = 1'b0;
    logic rst = 1'b1;
    logic blockPin_n = 1'b1;
    logic prioPin_n = 1'b1;
    logic softPin_n = 1'b1;
    logic testDone = 1'b0;
    logic enabled = 1'b0;
    logic [3:0] logicalId = 4'h0;
    logic dutOe, agentOe, flag, irq, fetch, wake, halted, shut, done;
    logic [7:0] vec;
    int n_errors = 0;
    int compares = 0;
    int irqs = 0;
    int fetches = 0;
    int wakes = 0;
    wire busLine = ~(dutOe | agentOe); // open-drain line, pulled high
    always #4 clock = ~clock;
    always #15 busClock = ~busClock;
    boot_arbiter #(.UNIT_ID(4'h3)) boot_arbiter_inst (.clock(clock), .rst(rst), .interruptBusClock(busClock),
        .busIn(busLine), .busOut_r(), .busOe_r(dutOe), .blockNextRequestPin_n(blockPin_n),
        .priorityAgentRequestPin_n(prioPin_n), .softInitPin_n(softPin_n), .selfTestDone(testDone),
        .unitEnabled(enabled), .logicalId(logicalId), .bootstrapFlag_r(flag), .coreIrq_r(irq),
        .fetchResetVector_r(fetch), .startupWake_r(wake), .startupVector_r(vec), .halted_r(halted),
        .shutdown_r(shut), .arbDone_r(done));
    // second unit on the same line
    bus_agent_model bus_agent_model_inst (.busClock(busClock), .busIn(busLine), .busOe(agentOe));
    // count one-cycle pulses
    always @(posedge clock) begin
        if (rst) begin
            // cleared by every reset, single writer
            irqs <= 0;
            fetches <= 0;
            wakes <= 0;
        end else begin
            irqs <= irqs + int'(irq === 1'b1);
            fetches <= fetches + int'(fetch === 1'b1);
            wakes <= wakes + int'(wake === 1'b1);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // boot message word from generation code and id
    function automatic logic [WORD_W-1:0] bootWord(input logic [3:0] gen, input logic [3:0] id);
        return {gen, id, MODE_FIXED, TRIG_EDGE, LEVEL_DEASSERT, DEST_PHYS, ALL_DEST};
    endfunction
    task automatic doReset();
        @(posedge clock);
        rst <= 1'b1;
        testDone <= 1'b0;
        blockPin_n <= 1'b1;
        bus_agent_model_inst.prio = 4'h5;
        bus_agent_model_inst.frames = 0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        // link reset release plus two bus clocks before any frame
        repeat (16) @(posedge clock);
    endtask
    task automatic waitFrames(input int n);
        for (int i = 0; i < 2000 && bus_agent_model_inst.frames < n; i++) @(posedge clock);
        repeat (10) @(posedge clock);
    endtask
    // unit alone: claims, wins, sends the final message, boots
    task automatic winAlone();
        doReset();
        check(flag, 0, "flag after reset");
        check(halted, 1, "halted after reset");
        testDone <= 1'b1;
        waitFrames(2);
        check(bus_agent_model_inst.words[0], bootWord(CLAIM_GEN, 4'h3), "claim word");
        check(bus_agent_model_inst.words[1], bootWord(FINAL_GEN, 4'h3), "final word");
        check({irqs[3:0], fetches[3:0]}, 8'h11, "irq and fetch pulses");
        check({flag, halted, done, shut}, 4'hA, "winner state");
    endtask
    // other unit claims first; this one waits for a startup message
    task automatic loseAndStart();
        doReset();
        blockPin_n <= 1'b0;
        // pin must be through its synchroniser before the test ends
        repeat (2) @(posedge clock);
        testDone <= 1'b1;
        enabled <= 1'b1;
        // longer than a whole frame: nothing may leave while held
        repeat (150) @(posedge clock);
        check(bus_agent_model_inst.frames, 0, "claim held by pin");
        // other unit claims before this unit's queued claim can start
        blockPin_n <= 1'b1;
        bus_agent_model_inst.sendFrame(bootWord(CLAIM_GEN, 4'h5), 1'b0);
        waitFrames(2);
        check(bus_agent_model_inst.words[1], bootWord(CLAIM_GEN, 4'h3), "claim after loss");
        check({irqs[3:0], flag, halted, done}, 7'h0B, "loser state");
        // startup only after arbitration is over
        bus_agent_model_inst.sendFrame({8'hBD, MODE_STARTUP, TRIG_EDGE, LEVEL_ASSERT, DEST_PHYS, 4'h3}, 1'b0);
        waitFrames(3);
        check({wakes[3:0], vec, halted}, 13'h037A, "startup wake");
        @(posedge clock);
        softPin_n <= 1'b0;
        repeat (4) @(posedge clock);
        softPin_n <= 1'b1;
        repeat (200) @(posedge clock);
        check({fetches[3:0], flag, halted}, 6'h01, "soft init");
        check(bus_agent_model_inst.frames, 3, "no new arbitration");
    endtask
    // bad checksum during arbitration
    task automatic badSum();
        doReset();
        blockPin_n <= 1'b0;
        // hold the claim back until the pin is synchronised
        repeat (2) @(posedge clock);
        testDone <= 1'b1;
        bus_agent_model_inst.sendFrame(bootWord(CLAIM_GEN, 4'h5), 1'b1);
        waitFrames(1);
        check({shut, flag}, 2'h2, "shutdown on bus error");
    endtask
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
    initial begin
        winAlone();
        loseAndStart();
        badSum();
        summarize();
    end
endmodule
